/* File: twrba_defs.svh */
// constants for the timer wide register byte access block
`ifndef TWRBA_DEFS_SVH
`define TWRBA_DEFS_SVH
// ----------------------------------------------------------------
// byte addresses of the timer's 16-bit registers
// ----------------------------------------------------------------
`define TWRBA_ADDR_CNT_LO 3'h0
`define TWRBA_ADDR_CNT_HI 3'h1
`define TWRBA_ADDR_CMPA_LO 3'h2
`define TWRBA_ADDR_CMPA_HI 3'h3
`define TWRBA_ADDR_CMPB_LO 3'h4
`define TWRBA_ADDR_CMPB_HI 3'h5
`define TWRBA_ADDR_CMPC_LO 3'h6
`define TWRBA_ADDR_CMPC_HI 3'h7
`define TWRBA_ADDR_CAP_LO 3'h0
`define TWRBA_ADDR_CAP_HI 3'h1
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TWRBA_BYTE_RST 8'h00
`define TWRBA_WORD_RST 16'h0000
// ----------------------------------------------------------------
// byte positions inside a 16-bit register and the counting step
// ----------------------------------------------------------------
`define TWRBA_HALF_BIT 0
`define TWRBA_HI_MSB 15
`define TWRBA_HI_LSB 8
`define TWRBA_LO_MSB 7
`define TWRBA_LO_LSB 0
`define TWRBA_COUNT_STEP 16'h0001
`endif

/* File: twrba_pkg.sv */
// types for the timer wide register byte access block
package twrba_pkg;
  typedef enum logic [2:0] {
    TWRBA_SEL_NONE,
    TWRBA_SEL_CNT,
    TWRBA_SEL_CMPA,
    TWRBA_SEL_CMPB,
    TWRBA_SEL_CMPC,
    TWRBA_SEL_CAP
  } twrba_sel_t;
endpackage

/* File: twrba_latch_if.sv */
// carrier between the access decoder and the shared high-byte latch
`timescale 1ns/10ps
interface twrba_latch_if;
  logic       load;
  logic [7:0] load_data;
  logic [7:0] hold;
  modport owner (input load, input load_data, output hold);
  modport user  (output load, output load_data, input hold);
endinterface

/* File: twrba_latch.sv */
// shared byte-wide holding latch of one timer
`timescale 1ns/10ps
`include "twrba_defs.svh"
module twrba_latch (
  input wire logic        mclk,
  input wire logic        sys_rst,
  twrba_latch_if.owner    port
);
  logic [7:0] hold;
  logic [7:0] next_hold;

  always_comb
  begin
    next_hold = hold;
    if (port.load)
    begin
      next_hold = port.load_data;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hold <= `TWRBA_BYTE_RST;
    end
    else
    begin
      hold <= next_hold;
    end
  end

  assign port.hold = hold;
endmodule // twrba_latch

/* File: twrba_access.sv */
// byte access to the 16-bit registers of one timer
`timescale 1ns/10ps
`include "twrba_defs.svh"
// Operation
// - each 16-bit register is two byte transfers, lower and upper half
// - one byte-wide holding latch per timer keeps the upper half
// - the latch is shared by all 16-bit registers of the timer
// - only the lower-half access moves all 16 bits at once
// - lower-half write loads latch byte and new byte together
// - counter or capture lower-half read copies the upper byte into the latch same cycle
// - compare reads neither use nor disturb the latch
// - latch keeps its byte, so one upper write serves many lower writes
// - counter upper-half accesses go to the latch, not the counter
// - processor counter write beats clear and count that cycle
module twrba_access (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [2:0]  bus_addr,
  input  wire logic        bus_cap_sel,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  input  wire logic        cnt_clear,
  input  wire logic        cnt_inc,
  input  wire logic        cnt_dec,
  input  wire logic        cap_load,
  output logic      [15:0] timer_count,
  output logic      [15:0] compare_value_a,
  output logic      [15:0] compare_value_b,
  output logic      [15:0] compare_value_c,
  output logic      [15:0] capture_value
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic twrba_pkg::twrba_sel_t dec_sel(input logic [2:0] a, input logic cap);
    if (cap)
      dec_sel = twrba_pkg::TWRBA_SEL_CAP;
    else if (a == `TWRBA_ADDR_CNT_LO || a == `TWRBA_ADDR_CNT_HI)
      dec_sel = twrba_pkg::TWRBA_SEL_CNT;
    else if (a == `TWRBA_ADDR_CMPA_LO || a == `TWRBA_ADDR_CMPA_HI)
      dec_sel = twrba_pkg::TWRBA_SEL_CMPA;
    else if (a == `TWRBA_ADDR_CMPB_LO || a == `TWRBA_ADDR_CMPB_HI)
      dec_sel = twrba_pkg::TWRBA_SEL_CMPB;
    else
      dec_sel = twrba_pkg::TWRBA_SEL_CMPC;
  endfunction

  function automatic logic [7:0] hi_byte(input logic [15:0] w);
    hi_byte = w[`TWRBA_HI_MSB:`TWRBA_HI_LSB];
  endfunction

  function automatic logic [7:0] lo_byte(input logic [15:0] w);
    lo_byte = w[`TWRBA_LO_MSB:`TWRBA_LO_LSB];
  endfunction

  twrba_pkg::twrba_sel_t sel;
  logic                  is_lo;
  logic                  wr_lo;
  logic [15:0]           wr_word;
  logic [15:0]           sel_word;

  twrba_latch_if latch_bus ();

  twrba_latch u_latch (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .port    (latch_bus.owner)
  );

  always_comb
  begin
    sel      = dec_sel(bus_addr, bus_cap_sel);
    is_lo    = ~bus_addr[`TWRBA_HALF_BIT];
    wr_lo    = bus_wr & is_lo;
    wr_word  = {latch_bus.hold, bus_wdata};
    case (sel)
      twrba_pkg::TWRBA_SEL_CNT:  sel_word = timer_count;
      twrba_pkg::TWRBA_SEL_CMPA: sel_word = compare_value_a;
      twrba_pkg::TWRBA_SEL_CMPB: sel_word = compare_value_b;
      twrba_pkg::TWRBA_SEL_CMPC: sel_word = compare_value_c;
      twrba_pkg::TWRBA_SEL_CAP:  sel_word = capture_value;
      default:                   sel_word = `TWRBA_WORD_RST;
    endcase
  end

  // ----------------------------------------------------------------
  // shared latch update
  // ----------------------------------------------------------------
  logic is_cmp;
  always_comb
  begin
    is_cmp = (sel == twrba_pkg::TWRBA_SEL_CMPA) || (sel == twrba_pkg::TWRBA_SEL_CMPB)
             || (sel == twrba_pkg::TWRBA_SEL_CMPC);
    latch_bus.load      = 1'b0;
    latch_bus.load_data = bus_wdata;
    if (bus_wr && !is_lo)
    begin
      latch_bus.load      = 1'b1;
      latch_bus.load_data = bus_wdata;
    end
    else if (bus_rd && is_lo && !is_cmp)
    begin
      latch_bus.load      = 1'b1;
      latch_bus.load_data = hi_byte(sel_word);
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic [15:0] next_count;
  logic        cnt_wr;

  // the write must win, or a tick in that cycle would lose the new word
  always_comb
  begin
    cnt_wr     = wr_lo && (sel == twrba_pkg::TWRBA_SEL_CNT);
    next_count = timer_count;
    if (cnt_wr)
    begin
      next_count = wr_word;
    end
    else if (cnt_clear)
    begin
      next_count = `TWRBA_WORD_RST;
    end
    else if (cnt_inc)
    begin
      next_count = timer_count + `TWRBA_COUNT_STEP;
    end
    else if (cnt_dec)
    begin
      next_count = timer_count - `TWRBA_COUNT_STEP;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timer_count <= `TWRBA_WORD_RST;
    end
    else
    begin
      timer_count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // compare values
  // ----------------------------------------------------------------
  logic [15:0] next_cmpa;
  logic [15:0] next_cmpb;
  logic [15:0] next_cmpc;

  always_comb
  begin
    next_cmpa = compare_value_a;
    next_cmpb = compare_value_b;
    next_cmpc = compare_value_c;
    if (wr_lo)
    begin
      case (sel)
        twrba_pkg::TWRBA_SEL_CMPA: next_cmpa = wr_word;
        twrba_pkg::TWRBA_SEL_CMPB: next_cmpb = wr_word;
        twrba_pkg::TWRBA_SEL_CMPC: next_cmpc = wr_word;
        default:                   next_cmpa = compare_value_a;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      compare_value_a <= `TWRBA_WORD_RST;
      compare_value_b <= `TWRBA_WORD_RST;
      compare_value_c <= `TWRBA_WORD_RST;
    end
    else
    begin
      compare_value_a <= next_cmpa;
      compare_value_b <= next_cmpb;
      compare_value_c <= next_cmpc;
    end
  end

  // ----------------------------------------------------------------
  // capture value
  // ----------------------------------------------------------------
  logic [15:0] next_cap;

  // a lower write beats a capture arriving in the same cycle
  always_comb
  begin
    next_cap = capture_value;
    if (wr_lo && (sel == twrba_pkg::TWRBA_SEL_CAP))
    begin
      next_cap = wr_word;
    end
    else if (cap_load)
    begin
      next_cap = timer_count;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      capture_value <= `TWRBA_WORD_RST;
    end
    else
    begin
      capture_value <= next_cap;
    end
  end

  // ----------------------------------------------------------------
  // read data, held until the next read
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = bus_rdata;
    if (bus_rd)
    begin
      if (is_lo)
      begin
        next_rdata = lo_byte(sel_word);
      end
      else if (is_cmp)
      begin
        next_rdata = hi_byte(sel_word);
      end
      else
      begin
        next_rdata = latch_bus.hold;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bus_rdata <= `TWRBA_BYTE_RST;
    end
    else
    begin
      bus_rdata <= next_rdata;
    end
  end
endmodule // twrba_access

/* File: twrba_properties.sv */
// assertions for the timer wide register byte access block
`timescale 1ns/10ps
module twrba_chk (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic [2:0]  bus_addr,
  input wire logic        bus_cap_sel,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic        cnt_clear,
  input wire logic [15:0] timer_count,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] compare_value_b,
  input wire logic [15:0] compare_value_c,
  input wire logic [15:0] capture_value
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic [7:0] hb;
  logic       cw;
  assign cw = bus_wr && !bus_cap_sel && bus_addr == 3'h0;
  // reference copy of the shared latch
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst) hb <= 8'h00;
    else if (bus_wr && bus_addr[0]) hb <= bus_wdata;
    else if (bus_rd && !bus_addr[0] && (bus_cap_sel || bus_addr == 3'h0))
      hb <= bus_cap_sel ? capture_value[15:8] : timer_count[15:8];
  property p_cwr; cw |=> timer_count == {$past(hb), $past(bus_wdata)}; endproperty
  a_cwr: assert property (p_cwr) else $error("count write");
  property p_awr;
    bus_wr && !bus_cap_sel && bus_addr == 3'h2 |=> compare_value_a == {$past(hb), $past(bus_wdata)};
  endproperty
  a_awr: assert property (p_awr) else $error("compare write");
  property p_hwr;
    bus_wr && bus_addr[0] |=> $stable(compare_value_a) && $stable(compare_value_b) && $stable(compare_value_c);
  endproperty
  a_hwr: assert property (p_hwr) else $error("upper write");
  property p_rlo;
    bus_rd && !bus_cap_sel && bus_addr == 3'h0 |=> bus_rdata == $past(timer_count[7:0]);
  endproperty
  a_rlo: assert property (p_rlo) else $error("count low read");
  property p_rhi; bus_rd && !bus_cap_sel && bus_addr == 3'h1 |=> bus_rdata == $past(hb); endproperty
  a_rhi: assert property (p_rhi) else $error("count high read");
  property p_rcb; bus_rd && !bus_cap_sel && bus_addr == 3'h5 |=> bus_rdata == compare_value_b[15:8]; endproperty
  a_rcb: assert property (p_rcb) else $error("compare high read");
  property p_rca; bus_rd && !bus_cap_sel && bus_addr == 3'h2 |=> bus_rdata == compare_value_a[7:0]; endproperty
  a_rca: assert property (p_rca) else $error("compare low read");
  property p_clr; cnt_clear && !cw |=> timer_count == 16'h0000; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  c_cw: cover property (cw);
  c_cap: cover property (bus_rd && bus_cap_sel);
  c_clr: cover property (cnt_clear);
endmodule // twrba_chk
bind twrba_access twrba_chk u_chk (
  .mclk            (mclk),
  .sys_rst         (sys_rst),
  .bus_addr        (bus_addr),
  .bus_cap_sel     (bus_cap_sel),
  .bus_wr          (bus_wr),
  .bus_rd          (bus_rd),
  .bus_wdata       (bus_wdata),
  .bus_rdata       (bus_rdata),
  .cnt_clear       (cnt_clear),
  .timer_count     (timer_count),
  .compare_value_a (compare_value_a),
  .compare_value_b (compare_value_b),
  .compare_value_c (compare_value_c),
  .capture_value   (capture_value)
);

/* File: twrba_cpu.sv */
// processor byte bus model
`timescale 1ns/10ps
module twrba_cpu (
  input  wire logic       mclk,
  output logic      [2:0] bus_addr,
  output logic            bus_cap_sel,
  output logic            bus_wr,
  output logic            bus_rd,
  output logic      [7:0] bus_wdata
);
  initial {bus_addr, bus_cap_sel, bus_wr, bus_rd, bus_wdata} = 14'h0000;
  // one master only, yet the bench still splits transfers, such as a counter read around a compare A read
  task automatic acc(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
    {bus_wr, bus_rd, bus_cap_sel, bus_addr} = {w, !w, c, a};
    bus_wdata = w ? d : ~bus_wdata;
    @(posedge mclk);
  endtask
  task automatic rel;
    {bus_wr, bus_rd} = 2'h0;
    bus_wdata = ~bus_wdata;
  endtask
endmodule // twrba_cpu

/* File: tb.sv */
// self-checking bench for the timer wide register byte access block
`timescale 1ns/10ps
module tb;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        rdp = 1'b0;
  logic [3:0]  f = 4'h0;
  logic [2:0]  bus_addr;
  logic        bus_cap_sel, bus_wr, bus_rd;
  logic [7:0]  bus_wdata, bus_rdata;
  logic [15:0] v [4];
  logic [7:0]  exq [$];
  int          seed = 53, err_total = 0, checks = 0;
  always #4 mclk = ~mclk;
  twrba_cpu cpu (.mclk(mclk), .bus_addr(bus_addr), .bus_cap_sel(bus_cap_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata));
  twrba_access DUT (.mclk(mclk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_cap_sel(bus_cap_sel), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .cnt_clear(f[3]), .cnt_inc(f[2]), .cnt_dec(f[1]),
    .cap_load(f[0]), .timer_count(), .compare_value_a(), .compare_value_b(), .compare_value_c(), .capture_value());
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %0t rdata %h exp %h", $time, s, e);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // g is {clear, inc, dec, capture} from the counting side
  task automatic acc(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d, input logic [3:0] g);
    #1 f = g;
    if (!w) exq.push_back(d);
    cpu.acc(w, c, a, d);
  endtask
  always @(posedge mclk) rdp <= bus_rd;
  always @(negedge mclk) if (rdp) chk(bus_rdata, exq.pop_front());
  initial
  begin
    repeat (8) @(posedge mclk);
    #1 sys_rst = 1'b0;
    @(posedge mclk);
    acc(0, 0, 3'h0, 8'h00, 4'h0);
    acc(0, 0, 3'h1, 8'h00, 4'h0);
    for (int k = 0; k < 4; k++)
    begin
      v[k] = 16'($random(seed));
      acc(1, 0, 3'(2 * k + 1), v[k][15:8], 4'h0);
      acc(1, 0, 3'(2 * k), v[k][7:0], k == 0 ? 4'h6 : 4'h0);
    end
    for (int k = 0; k < 4; k++)
    begin
      acc(0, 0, 3'(2 * k), v[k][7:0], 4'h0);
      acc(0, 0, 3'(2 * k + 1), v[k][15:8], 4'h0);
    end
    acc(0, 0, 3'h0, v[0][7:0], 4'h0);
    acc(0, 0, 3'h2, v[1][7:0], 4'h0);
    acc(0, 0, 3'h1, v[0][15:8], 4'h0);
    acc(1, 1, 3'h1, 8'hA5, 4'h0);
    acc(0, 0, 3'h3, v[1][15:8], 4'h0);
    acc(1, 0, 3'h2, 8'h3C, 4'h0);
    acc(1, 0, 3'h0, 8'h5A, 4'h0);
    acc(0, 0, 3'h2, 8'h3C, 4'h1);
    acc(0, 0, 3'h3, 8'hA5, 4'h8);
    acc(0, 1, 3'h0, 8'h5A, 4'h4);
    acc(0, 1, 3'h1, 8'hA5, 4'h4);
    acc(0, 0, 3'h0, 8'h02, 4'h2);
    acc(0, 0, 3'h1, 8'h00, 4'h0);
    #1 cpu.rel();
    repeat (2) @(posedge mclk);
    finish_test();
  end
  initial
  begin
    #5000;
    err_total++;
    finish_test();
  end
endmodule // tb
